/* File: logic/wdt_cfg.svh */
// Purpose: Constants for the windowed watchdog timer.
// Assumes: 50 MHz mclk_i, AXI4-Lite register access.
// Notes:   Definitions only.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Register byte addresses
`define WDT_ADDR_SRS        32'h0000_0000
`define WDT_ADDR_OPT1       32'h0000_0004
`define WDT_ADDR_OPT2       32'h0000_0008
`define WDT_ADDR_CNT        32'h0000_000C

// Service values
`define WDT_SVC_FIRST       16'h0055
`define WDT_SVC_SECOND      16'h00AA

// Timeout select encodings and option reset values
`define WDT_TSEL_OFF        2'h0
`define WDT_TSEL_SHORT      2'h1
`define WDT_TSEL_MID        2'h2
`define WDT_TSEL_LONG       2'h3
`define WDT_TSEL_RST        2'h3
`define WDT_CLKS_RST        1'h0
`define WDT_WIN_RST         1'h0

// Field positions
`define WDT_OPT1_TSEL_LSB   0
`define WDT_OPT1_TSEL_MSB   1
`define WDT_OPT2_CLKS_BIT   0
`define WDT_OPT2_WIN_BIT    1
`define WDT_SRS_TMO_BIT     0
`define WDT_SRS_ILL_BIT     1
`define WDT_OPT_LOCK_BIT    7

// Overflow counts on the 1 kHz source
`define WDT_LPO_OVF_SHORT   19'h00020
`define WDT_LPO_OVF_MID     19'h00100
`define WDT_LPO_OVF_LONG    19'h00400

// Overflow counts and window openings on the bus clock
`define WDT_BUS_OVF_SHORT   8192
`define WDT_BUS_OVF_MID     65536
`define WDT_BUS_OVF_LONG    262144
`define WDT_BUS_WIN_SHORT   6144
`define WDT_BUS_WIN_MID     49152
`define WDT_BUS_WIN_LONG    196608

// Timing
`define WDT_LPO_PERIOD_NS   1000000
`define WDT_CLK_PERIOD_NS   20

// AXI responses
`define WDT_RESP_OKAY       2'h0
`define WDT_RESP_SLVERR     2'h2

`endif

/* File: logic/wdt_lpo_tick.sv */
// Purpose: One-cycle tick at the low power oscillator rate.
// Assumes: Divider value of at least two.
// Notes:   Restarts while clear_i is high.
`timescale 1ns/1ns
`default_nettype none
module wdt_lpo_tick #(
	parameter int unsigned DIV = 50000
) (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	input  wire logic clear_i,
	output logic      tick_o
);
	logic [31:0] div_cnt;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || clear_i) begin
			div_cnt <= 32'h0;
		end else if (div_cnt == 32'(DIV - 1)) begin
			div_cnt <= 32'h0;
		end else begin
			div_cnt <= div_cnt + 32'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || clear_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= (div_cnt == 32'(DIV - 1));
		end
	end
endmodule
`default_nettype wire

/* File: logic/wdt_pkg.sv */
// Purpose: Types for the windowed watchdog timer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in wdt_cfg.svh.
package wdt_pkg;
	typedef logic [31:0] axi_addr_t;
	typedef logic [31:0] axi_data_t;
	typedef logic [18:0] wdt_count_t;
	typedef enum logic [1:0] {
		SVC_IDLE  = 2'h0,
		SVC_ARMED = 2'h1
	} svc_state_t;
	typedef enum logic [2:0] {
		SEL_SRS  = 3'h0,
		SEL_OPT1 = 3'h1,
		SEL_OPT2 = 3'h3,
		SEL_CNT  = 3'h2,
		SEL_NONE = 3'h6
	} reg_sel_t;
endpackage

/* File: logic/windowed_watchdog_timer.sv */
// Purpose: Windowed watchdog with AXI4-Lite registers and a reset request pulse.
// Assumes: sys_rst_i is asserted by the system after every reset request.
// Notes:   por_rst_i clears the reset cause record as well.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module windowed_watchdog_timer #(
	parameter int unsigned LPO_TICK_CYCLES = `WDT_LPO_PERIOD_NS / `WDT_CLK_PERIOD_NS,
	parameter int unsigned BUS_OVF_SHORT   = `WDT_BUS_OVF_SHORT,
	parameter int unsigned BUS_OVF_MID     = `WDT_BUS_OVF_MID,
	parameter int unsigned BUS_OVF_LONG    = `WDT_BUS_OVF_LONG,
	parameter int unsigned BUS_WIN_SHORT   = `WDT_BUS_WIN_SHORT,
	parameter int unsigned BUS_WIN_MID     = `WDT_BUS_WIN_MID,
	parameter int unsigned BUS_WIN_LONG    = `WDT_BUS_WIN_LONG
) (
	input  wire logic              mclk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              por_rst_i,
	input  wire logic              debug_active_i,
	input  wire logic              stop_active_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire wdt_pkg::axi_addr_t s_axi_awaddr_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	input  wire wdt_pkg::axi_data_t s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	output logic [1:0]             s_axi_bresp_o,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	input  wire wdt_pkg::axi_addr_t s_axi_araddr_i,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	output wdt_pkg::axi_data_t     s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   wdt_reset_req_o
);
	import wdt_pkg::*;

	function automatic reg_sel_t decode(input axi_addr_t addr);
		if (addr == `WDT_ADDR_SRS) begin
			decode = SEL_SRS;
		end else if (addr == `WDT_ADDR_OPT1) begin
			decode = SEL_OPT1;
		end else if (addr == `WDT_ADDR_OPT2) begin
			decode = SEL_OPT2;
		end else if (addr == `WDT_ADDR_CNT) begin
			decode = SEL_CNT;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	function automatic wdt_count_t limit(input logic bus, input logic [1:0] sel, input logic win);
		int unsigned v;
		v = 0;
		case (sel)
			`WDT_TSEL_SHORT: v = bus ? (win ? BUS_WIN_SHORT : BUS_OVF_SHORT) : int'(`WDT_LPO_OVF_SHORT);
			`WDT_TSEL_MID:   v = bus ? (win ? BUS_WIN_MID : BUS_OVF_MID) : int'(`WDT_LPO_OVF_MID);
			default:         v = bus ? (win ? BUS_WIN_LONG : BUS_OVF_LONG) : int'(`WDT_LPO_OVF_LONG);
		endcase
		limit = wdt_count_t'(v);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic       aw_held;
	logic       w_held;
	axi_addr_t  aw_addr;
	axi_data_t  w_data;
	logic [3:0] w_strb;
	logic       wr_fire;
	reg_sel_t   wr_sel;
	logic       rd_fire;

	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign wr_fire         = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_sel          = decode(aw_addr);
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_fire         = s_axi_arvalid_i && s_axi_arready_o;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || wr_fire) begin
			aw_held <= 1'b0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || wr_fire) begin
			w_held <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			aw_addr <= 32'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `WDT_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write-once configuration
	logic [1:0] timeout_select;
	logic       watchdog_clock_select;
	logic       window_mode_enable;
	logic       opt1_locked;
	logic       opt2_locked;
	logic       opt1_wr;
	logic       opt2_wr;

	assign opt1_wr = wr_fire && (wr_sel == SEL_OPT1) && w_strb[0];
	assign opt2_wr = wr_fire && (wr_sel == SEL_OPT2) && w_strb[0];

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			timeout_select <= `WDT_TSEL_RST;
			opt1_locked    <= 1'b0;
		end else if (opt1_wr && !opt1_locked) begin
			timeout_select <= w_data[`WDT_OPT1_TSEL_MSB:`WDT_OPT1_TSEL_LSB];
			opt1_locked    <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			watchdog_clock_select <= `WDT_CLKS_RST;
			window_mode_enable    <= `WDT_WIN_RST;
			opt2_locked           <= 1'b0;
		end else if (opt2_wr && !opt2_locked) begin
			watchdog_clock_select <= w_data[`WDT_OPT2_CLKS_BIT];
			window_mode_enable    <= w_data[`WDT_OPT2_WIN_BIT];
			opt2_locked           <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counter, service sequence and reset request
	wdt_count_t count;
	wdt_count_t ovf_lim;
	wdt_count_t win_open;
	svc_state_t svc_state;
	logic       enabled;
	logic       freeze;
	logic       lpo_tick;
	logic       inc;
	logic       win_active;
	logic       srs_wr;
	logic       is_first;
	logic       is_second;
	logic       early;
	logic       svc_done;
	logic       timeout;
	logic       illegal;
	logic       cfg_wr;

	wdt_lpo_tick #(
		.DIV       (LPO_TICK_CYCLES)
	) u_lpo_tick (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.clear_i   (freeze),
		.tick_o    (lpo_tick)
	);

	assign enabled    = (timeout_select != `WDT_TSEL_OFF);
	assign freeze     = debug_active_i || stop_active_i;
	assign inc        = watchdog_clock_select ? 1'b1 : lpo_tick;
	assign ovf_lim    = limit(watchdog_clock_select, timeout_select, 1'b0);
	assign win_open   = limit(1'b1, timeout_select, 1'b1);
	assign win_active = watchdog_clock_select && window_mode_enable;
	assign srs_wr     = wr_fire && (wr_sel == SEL_SRS);
	assign is_first   = (w_data[15:0] == `WDT_SVC_FIRST);
	assign is_second  = (w_data[15:0] == `WDT_SVC_SECOND);
	assign early      = win_active && (count < win_open);
	assign svc_done   = enabled && srs_wr && is_second && !early && (svc_state == SVC_ARMED);
	assign timeout    = enabled && !freeze && inc && (count == ovf_lim - 19'h1);
	assign illegal    = enabled && srs_wr && (!(is_first || is_second) || early);
	assign cfg_wr     = (opt1_wr && !opt1_locked) || (opt2_wr && !opt2_locked);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !enabled || cfg_wr || timeout || illegal) begin
			svc_state <= SVC_IDLE;
		end else if (srs_wr && is_first) begin
			svc_state <= SVC_ARMED;
		end else if (svc_done) begin
			svc_state <= SVC_IDLE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !enabled || cfg_wr || svc_done || timeout || illegal) begin
			count <= 19'h0;
		end else if (freeze) begin
			if (!watchdog_clock_select) begin
				count <= 19'h0;
			end
		end else if (inc) begin
			count <= count + 19'h1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wdt_reset_req_o <= 1'b0;
		end else begin
			wdt_reset_req_o <= timeout || illegal;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset cause record and read port
	logic [1:0] last_cause;
	logic [1:0] reset_status;
	logic       rst_prev;

	// First cycle of a reset, so a long reset keeps the cause
	always_ff @(posedge mclk_i) begin
		rst_prev <= sys_rst_i;
	end

	always_ff @(posedge mclk_i) begin
		if (por_rst_i) begin
			last_cause   <= 2'h0;
			reset_status <= 2'h0;
		end else if (sys_rst_i) begin
			if (!rst_prev) begin
				reset_status <= last_cause;
				last_cause   <= 2'h0;
			end
		end else if (timeout) begin
			last_cause <= 2'h1 << `WDT_SRS_TMO_BIT;
		end else if (illegal) begin
			last_cause <= 2'h1 << `WDT_SRS_ILL_BIT;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0;
			s_axi_rresp_o  <= `WDT_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= `WDT_RESP_OKAY;
			case (decode(s_axi_araddr_i))
				SEL_SRS:  s_axi_rdata_o <= {30'h0, reset_status};
				SEL_OPT1: s_axi_rdata_o <= {24'h0, opt1_locked, 5'h0, timeout_select};
				SEL_OPT2: s_axi_rdata_o <= {24'h0, opt2_locked, 5'h0, window_mode_enable,
					watchdog_clock_select};
				SEL_CNT:  s_axi_rdata_o <= {13'h0, count};
				default: begin
					s_axi_rdata_o <= 32'h0;
					s_axi_rresp_o <= `WDT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_armed_service;
		(svc_state == SVC_ARMED) ##0 (srs_wr && is_second && enabled && !early);
	endsequence
	sequence s_early_service;
		srs_wr && enabled && win_active && (count < win_open) && (is_first || is_second);
	endsequence

	a_reset_defaults: assert property ($past(sys_rst_i) |->
		timeout_select == `WDT_TSEL_RST && !watchdog_clock_select && !window_mode_enable && count == 19'h0)
		else $error("watchdog not at defaults after reset");
	a_disabled_quiet: assert property ($past(!enabled) && !$past(illegal) |-> !wdt_reset_req_o)
		else $error("reset request while disabled");
	a_service_clear: assert property (s_armed_service |=> count == 19'h0 && svc_state == SVC_IDLE)
		else $error("service sequence did not clear counter");
	a_status_kept: assert property (srs_wr |=> $stable(reset_status))
		else $error("service write changed status");
	a_overflow_req: assert property (timeout |=> wdt_reset_req_o ##1 (count < 19'h2))
		else $error("overflow without reset request");
	a_illegal_req: assert property (srs_wr && enabled && !is_first && !is_second |=> wdt_reset_req_o)
		else $error("illegal service value not punished");
	a_lpo_gated: assert property (!watchdog_clock_select && !lpo_tick && !freeze && !cfg_wr && !svc_done && !illegal
		|=> $stable(count))
		else $error("1 kHz counter moved without tick");
	a_lpo_limits: assert property (!watchdog_clock_select && timeout_select == `WDT_TSEL_SHORT
		|-> ovf_lim == `WDT_LPO_OVF_SHORT)
		else $error("wrong 1 kHz overflow count");
	a_bus_limits: assert property (watchdog_clock_select && timeout_select == `WDT_TSEL_MID
		|-> ovf_lim == wdt_count_t'(BUS_OVF_MID) && win_open == wdt_count_t'(BUS_WIN_MID))
		else $error("wrong bus overflow or window count");
	a_early_reset: assert property (s_early_service |=> wdt_reset_req_o)
		else $error("early windowed service not punished");
	a_no_lpo_window: assert property (!watchdog_clock_select && srs_wr && is_first && !timeout
		|=> !wdt_reset_req_o)
		else $error("window applied on 1 kHz source");
	a_config_lock: assert property (opt1_locked && opt2_locked |=>
		$stable(timeout_select) && $stable(watchdog_clock_select) && $stable(window_mode_enable))
		else $error("locked configuration changed");
	a_bus_freeze: assert property (watchdog_clock_select && freeze && enabled && !cfg_wr && !svc_done
		&& !illegal |=> $stable(count))
		else $error("bus counter moved while frozen");
	a_lpo_freeze: assert property (!watchdog_clock_select && freeze |=> count == 19'h0)
		else $error("1 kHz counter not cleared while frozen");
	a_cause_record: assert property (timeout && !por_rst_i |=> last_cause[`WDT_SRS_TMO_BIT])
		else $error("timeout cause not recorded");
	a_req_pulse: assert property (wdt_reset_req_o |=> !wdt_reset_req_o)
		else $error("reset request longer than one cycle");
endmodule
`default_nettype wire

/* File: test/tb_windowed_watchdog_timer.sv */
// Purpose: Self-checking bench for the windowed watchdog timer over AXI4-Lite.
// Assumes: Shortened counts: tick of 4 cycles, bus overflows 64/128/256.
// Notes:   Bench asserts sys_rst_i after every reset request, as the system would.
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module tb_windowed_watchdog_timer;
	import wdt_pkg::*;
	localparam int LPO = 4;
	localparam int OVF [1:3] = '{64, 128, 256};
	localparam int WIN [1:3] = '{48, 96, 192};
	logic       mclk_i = 0, sys_rst_i = 1, por_rst_i = 1, debug_active_i = 0, stop_active_i = 0;
	logic       s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic       s_axi_arvalid_i = 0, s_axi_rready_i = 0;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	axi_addr_t  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	axi_data_t  s_axi_wdata_i = '0, s_axi_rdata_o;
	logic       s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
	logic       wdt_reset_req_o, req_prev = 0;
	int         n_errors = 0, comparisons = 0, cyc = 0, req_cnt = 0, req_time = 0, base, t0, dt, req0;
	axi_data_t  rd, c1, c2;

	windowed_watchdog_timer #(.LPO_TICK_CYCLES(LPO), .BUS_OVF_SHORT(64), .BUS_OVF_MID(128),
		.BUS_OVF_LONG(256), .BUS_WIN_SHORT(48), .BUS_WIN_MID(96), .BUS_WIN_LONG(192)) dut (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i),
		.debug_active_i(debug_active_i), .stop_active_i(stop_active_i),
		.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
		.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o), .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
		.s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
		.wdt_reset_req_o(wdt_reset_req_o));

	initial begin
		forever #10 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic near(input int seen, input int exp, input int tol, input string what);
		check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1, what);
	endtask

	task automatic results;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Request monitor: counts pulses and checks their width
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (wdt_reset_req_o) begin
			req_cnt <= req_cnt + 1;
			req_time <= cyc;
			check(32'(req_prev), 32'h0, "request wider than one cycle");
		end
		req_prev <= wdt_reset_req_o;
	end

	initial begin
		#2000000;
		n_errors++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic p);
		@(posedge mclk_i);
		sys_rst_i <= 1;
		por_rst_i <= p;
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 0;
		por_rst_i <= 0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic axi_write(input axi_addr_t a, input axi_data_t d);
		int n;
		n = 0;
		@(posedge mclk_i);
		s_axi_awvalid_i <= 1;
		s_axi_awaddr_i <= a;
		s_axi_wvalid_i <= 1;
		s_axi_wdata_i <= d;
		s_axi_bready_i <= 1;
		forever begin
			@(posedge mclk_i);
			n++;
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 0;
			if (s_axi_bvalid_o) begin
				resp = s_axi_bresp_o;
				s_axi_bready_i <= 0;
				break;
			end
			if (n > 1000) begin
				check(32'h0, 32'h1, "write never answered");
				break;
			end
		end
		base = req_cnt;
		t0 = cyc;
	endtask

	task automatic axi_read(input axi_addr_t a, output axi_data_t d);
		int n;
		n = 0;
		@(posedge mclk_i);
		s_axi_arvalid_i <= 1;
		s_axi_araddr_i <= a;
		s_axi_rready_i <= 1;
		forever begin
			@(posedge mclk_i);
			n++;
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 0;
			if (s_axi_rvalid_o) begin
				d = s_axi_rdata_o;
				resp = s_axi_rresp_o;
				s_axi_rready_i <= 0;
				break;
			end
			if (n > 1000) begin
				check(32'h0, 32'h1, "read never answered");
				break;
			end
		end
	endtask

	task automatic wait_req(input int limit);
		int n;
		n = 0;
		while (req_cnt == base && n < limit) begin
			@(posedge mclk_i);
			n++;
		end
		@(posedge mclk_i);
		dt = (req_cnt == base) ? -1 : req_time - t0;
	endtask

	task automatic service;
		axi_write(`WDT_ADDR_SRS, 32'(`WDT_SVC_FIRST));
		axi_write(`WDT_ADDR_SRS, 32'(`WDT_SVC_SECOND));
	endtask

	function automatic int lpo_ovf(input int s);
		return s == 1 ? int'(`WDT_LPO_OVF_SHORT) : s == 2 ? int'(`WDT_LPO_OVF_MID) : int'(`WDT_LPO_OVF_LONG);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1);
		base = req_cnt;
		t0 = cyc;
		axi_read(`WDT_ADDR_OPT1, rd);
		check(rd, 32'h3, "options one default");
		axi_read(`WDT_ADDR_OPT2, rd);
		check(rd, 32'h0, "options two default");
		axi_read(`WDT_ADDR_CNT, c1);
		idle(20);
		axi_read(`WDT_ADDR_CNT, c2);
		check(32'(c2 !== c1), 32'h1, "counting after reset");
		wait_req(5000);
		near(dt, lpo_ovf(3) * LPO, 8, "default timeout");
		do_reset(0);
		axi_read(`WDT_ADDR_SRS, rd);
		check(rd, 32'h1, "timeout cause");
		$display("test default timeout done");

		for (int s = 1; s < 4; s++) begin
			for (int k = 0; k < 2; k++) begin
				do_reset(0);
				axi_write(`WDT_ADDR_OPT2, 32'(k));
				axi_write(`WDT_ADDR_OPT1, 32'(s));
				wait_req(5000);
				near(dt, k ? OVF[s] : lpo_ovf(s) * LPO, k ? 4 : 8, "overflow count");
			end
		end
		$display("test overflow table done");

		do_reset(1);
		s_axi_wstrb_i <= 4'hE;
		axi_write(`WDT_ADDR_OPT1, 32'h2);
		s_axi_wstrb_i <= 4'hF;
		axi_write(`WDT_ADDR_OPT1, 32'h1);
		axi_write(`WDT_ADDR_OPT2, 32'h0);
		axi_write(`WDT_ADDR_OPT1, 32'h3);
		axi_read(`WDT_ADDR_OPT1, rd);
		check(rd, 32'h81, "options one locked");
		axi_read(`WDT_ADDR_OPT2, rd);
		check(rd, 32'h80, "options two locked");
		axi_write(32'h10, 32'h0);
		check(32'(resp), 32'(`WDT_RESP_SLVERR), "unmapped write");
		axi_read(32'h10, rd);
		check(32'(resp), 32'(`WDT_RESP_SLVERR), "unmapped read");
		req0 = req_cnt;
		for (int i = 0; i < 6; i++) begin
			idle(80);
			service();
		end
		check(32'(req_cnt - req0), 32'h0, "serviced run");
		axi_read(`WDT_ADDR_SRS, rd);
		check(rd, 32'h0, "status untouched by service");
		wait_req(500);
		near(dt, lpo_ovf(1) * LPO, 8, "locked short timeout");
		$display("test service and lock done");

		do_reset(0);
		axi_write(`WDT_ADDR_SRS, 32'h12);
		wait_req(10);
		near(dt, 1, 2, "illegal value reset");
		do_reset(0);
		axi_read(`WDT_ADDR_SRS, rd);
		check(rd, 32'h2, "illegal write cause");
		$display("test illegal write done");

		for (int s = 1; s < 4; s++) begin
			do_reset(0);
			axi_write(`WDT_ADDR_OPT2, 32'h3);
			axi_write(`WDT_ADDR_OPT1, 32'(s));
			idle(WIN[s] - 12);
			axi_write(`WDT_ADDR_SRS, 32'(`WDT_SVC_FIRST));
			wait_req(10);
			near(dt, 1, 2, "premature service");
			do_reset(0);
			axi_write(`WDT_ADDR_OPT2, 32'h3);
			axi_write(`WDT_ADDR_OPT1, 32'(s));
			idle(WIN[s] + 2);
			req0 = req_cnt;
			service();
			idle(4);
			check(32'(req_cnt - req0), 32'h0, "service inside window");
		end
		do_reset(0);
		axi_write(`WDT_ADDR_OPT2, 32'h2);
		axi_write(`WDT_ADDR_OPT1, 32'h1);
		req0 = req_cnt;
		service();
		idle(4);
		check(32'(req_cnt - req0), 32'h0, "no window on slow clock");
		$display("test window done");

		do_reset(0);
		axi_write(`WDT_ADDR_OPT2, 32'h1);
		axi_write(`WDT_ADDR_OPT1, 32'h2);
		idle(30);
		debug_active_i <= 1;
		axi_read(`WDT_ADDR_CNT, c1);
		idle(300);
		axi_read(`WDT_ADDR_CNT, c2);
		check(c2, c1, "bus count held in debug");
		check(32'(req_cnt - base), 32'h0, "no timeout while held");
		debug_active_i <= 0;
		t0 = cyc;
		wait_req(200);
		near(dt, 64, 64, "bus count resumes");
		do_reset(0);
		idle(200);
		stop_active_i <= 1;
		idle(5);
		axi_read(`WDT_ADDR_CNT, rd);
		check(rd, 32'h0, "slow count cleared in stop");
		base = req_cnt;
		idle(5000);
		check(32'(req_cnt - base), 32'h0, "no timeout in stop");
		stop_active_i <= 0;
		t0 = cyc;
		wait_req(5000);
		near(dt, lpo_ovf(3) * LPO, 8, "slow count restarts");
		$display("test freeze done");

		do_reset(0);
		axi_write(`WDT_ADDR_OPT1, 32'h0);
		req0 = req_cnt;
		idle(5000);
		axi_write(`WDT_ADDR_SRS, 32'h12);
		idle(10);
		check(32'(req_cnt - req0), 32'h0, "disabled watchdog");
		$display("test disabled done");
		results();
	end
endmodule
`default_nettype wire
